// *** core/rfid_ctrl_pkg.sv ***
// Constants, register map and types for the protocol select and
// signal strength capture block.
// Assumes one 100 MHz system clock and a byte-wide register port.
package rfid_ctrl_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int MEAS_TIME_US = 50;
    localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
    localparam int LOW_RATE_KHZ = 60;
    localparam int LOW_RATE_HALF = (CLK_MHZ * 1000) / (2 * LOW_RATE_KHZ);
    localparam int DIV_W = 10;

    // Register addresses
    localparam logic [4:0] ADDR_CHIP_STATUS = 5'h00;
    localparam logic [4:0] ADDR_PROTOCOL = 5'h01;
    localparam logic [4:0] ADDR_HBR_OPTIONS = 5'h03;
    localparam logic [4:0] ADDR_MOD_SYSCLK = 5'h09;
    localparam logic [4:0] ADDR_SIG_STATUS = 5'h0F;

    // Reset and preset values
    localparam logic [7:0] CHIP_STATUS_RST = 8'h00;
    localparam logic [7:0] PROTOCOL_RST = 8'h02;
    localparam logic [7:0] HBR_OPTIONS_RST = 8'h00;
    localparam logic [7:0] MOD_SYSCLK_RST = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Direct commands
    localparam logic [7:0] CMD_SIGNAL_STRENGTH_CODE_INT = 8'h18;
    localparam logic [7:0] CMD_SIGNAL_STRENGTH_CODE_EXT = 8'h19;

    // Field positions
    localparam int CS_EXT_SEL_BIT = 1;
    localparam int PS_READER_BIT = 5;
    localparam int PS_CODE_MSB = 4;
    localparam int HBR_SPLIT_BIT = 0;
    localparam int HBR_TX_LSB = 1;
    localparam int MOD_DIV_LSB = 4;
    localparam int SIG_FIXED_BIT = 6;
    localparam int SIG_AUX_LSB = 3;

    // Protocol codes of interest
    localparam logic [4:0] CODE_TYPE_A_FIRST = 5'h08;
    localparam logic [4:0] CODE_TYPE_B_FIRST = 5'h0C;
    localparam logic [4:0] CODE_PROP_212 = 5'h1A;
    localparam logic [4:0] CODE_PROP_424 = 5'h1B;

    typedef enum logic [2:0] {
        FAMILY_VICINITY = 3'h0,
        FAMILY_TYPE_A = 3'h1,
        FAMILY_TYPE_B = 3'h2,
        FAMILY_PROP = 3'h3,
        FAMILY_RESERVED = 3'h4
    } family_type;

    typedef enum logic [1:0] {
        RATE_106 = 2'h0,
        RATE_212 = 2'h1,
        RATE_424 = 2'h2,
        RATE_848 = 2'h3
    } rate_type;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'h0,
        MEAS_INT = 2'h1,
        MEAS_EXT = 2'h3
    } meas_state_type;

    // System clock divide selections
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;

endpackage

// *** core/sysclk_divider.sv ***
// Glitch-free divider for the system clock output.
// Assumes a synchronous ratio and low-rate select from the main block.
`timescale 1ns/1ps
`default_nettype none

module sysclk_divider (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [1:0] ratio_i,
    input wire logic low_rate_i,
    output logic clk_out_o
);

    typedef struct packed {
        logic [rfid_ctrl_pkg::DIV_W-1:0] count;
        logic [rfid_ctrl_pkg::DIV_W-1:0] half;
        logic level;
    } div_state_type;

    div_state_type state;
    div_state_type next_state;
    logic [rfid_ctrl_pkg::DIV_W-1:0] want_half;

    always_comb begin
        if (low_rate_i) begin
            want_half = rfid_ctrl_pkg::DIV_W'(rfid_ctrl_pkg::LOW_RATE_HALF);
        end else if (ratio_i == rfid_ctrl_pkg::DIV_BY_1) begin
            want_half = rfid_ctrl_pkg::DIV_W'(1);
        end else if (ratio_i == rfid_ctrl_pkg::DIV_BY_2) begin
            want_half = rfid_ctrl_pkg::DIV_W'(2);
        end else begin
            want_half = rfid_ctrl_pkg::DIV_W'(4);
        end
        next_state = state;
        if (state.count + rfid_ctrl_pkg::DIV_W'(1) >= state.half) begin
            next_state.count = '0;
            next_state.level = ~state.level;
            if (state.level) begin
                next_state.half = want_half;
            end
        end else begin
            next_state.count = state.count + rfid_ctrl_pkg::DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= '{count: '0, half: rfid_ctrl_pkg::DIV_W'(1), level: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign clk_out_o = state.level;

endmodule

`default_nettype wire

// *** core/protocol_select_signal_strength_code_capture.sv ***
// Protocol decode, signal strength capture and system clock output
// control of a contactless reader front end.
// Assumes a byte register port and command strobe on the system clock;
// analog codes and enable pins arrive asynchronously.
//
// How it works
// - Bits 4:0 code, bit 5 forced reader
// - Protocol write presets related registers
// - Decode vicinity, Type A, Type B variants
// - Default: vicinity high rate, 1-of-4
// - Split rates: 212 code gives receive rate
// - Peak level latched during received packet
// - Stored strength cleared at each transmission
// - Two 3-bit codes stored in status
// - Chip status bit 1 picks source
// - Command 0x18 runs internal measurement
// - Command 0x19 measures external carrier level
// - Status reads between 0x40 and 0x7F
// - Reading status clears it
// - One crystal clock drives carrier and logic
// - Output clock divided by 2, 4, 8
// - Power-down mode 2 gives 60 kHz
`timescale 1ns/1ps
`default_nettype none

module protocol_select_signal_strength_code_capture #(
    parameter int MEAS_CYCLES = rfid_ctrl_pkg::MEAS_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic tx_start_i,
    input wire logic rx_packet_i,
    input wire logic [2:0] main_strength_i,
    input wire logic [2:0] aux_strength_i,
    input wire logic [2:0] first_receiver_input_level_i,
    input wire logic enable_pin_i,
    input wire logic secondary_enable_pin_i,
    output logic [7:0] reg_rdata_o,
    output logic preset_o,
    output logic [2:0] family_o,
    output logic coding_256_o,
    output logic high_rate_o,
    output logic dual_subcarrier_o,
    output logic [1:0] rx_rate_o,
    output logic [1:0] tx_rate_o,
    output logic measuring_o,
    output logic system_clock_out_o
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] chip_status;
        logic [7:0] protocol;
        logic [7:0] hbr_options;
        logic [7:0] mod_sysclk;

        logic [2:0] main_peak;
        logic [2:0] aux_peak;
        logic [2:0] ext_peak;
        rfid_ctrl_pkg::meas_state_type meas;
        logic measuring;
        logic [15:0] meas_count;

        // Registered so outputs leave straight from flops
        logic [7:0] rdata;
        logic preset;
        rfid_ctrl_pkg::family_type family;
        logic coding_256;
        logic high_rate;
        logic dual_sub;
        rfid_ctrl_pkg::rate_type rx_rate;
        rfid_ctrl_pkg::rate_type tx_rate;

        // Two stages each; only the second is read
        logic [1:0] rx_sync;
        logic [5:0] main_sync0;
        logic [5:0] main_sync1;
        logic [5:0] ext_sync;
        logic [3:0] en_sync;
    } core_state_type;

    core_state_type state;
    core_state_type next_state;

    logic [2:0] main_now;
    logic [2:0] aux_now;
    logic [2:0] ext_now;
    logic rx_now;
    logic low_rate;
    logic [7:0] sig_value;
    logic capture_int;
    logic capture_ext;
    logic [4:0] code;

    ////////////////////////////////////////////////////////////////////
    // Synchronised inputs, read only past the second stage

    assign main_now = state.main_sync1[2:0];
    assign aux_now = state.main_sync1[5:3];
    assign ext_now = state.ext_sync[5:3];
    assign rx_now = state.rx_sync[1];
    assign low_rate = !state.en_sync[2] && state.en_sync[3];

    // both codes share the status byte
    // fixed bit keeps reads within 0x40..0x7F
    always_comb begin
        sig_value = '0;
        sig_value[rfid_ctrl_pkg::SIG_FIXED_BIT] = 1'b1;

        if (state.chip_status[rfid_ctrl_pkg::CS_EXT_SEL_BIT]) begin
            sig_value[2:0] = state.ext_peak;
        end else begin
            sig_value[2:0] = state.main_peak;
            sig_value[rfid_ctrl_pkg::SIG_AUX_LSB +: 3] = state.aux_peak;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        next_state.preset = 1'b0;

        // Pin inputs shift through two flops
        next_state.rx_sync = {state.rx_sync[0], rx_packet_i};
        next_state.main_sync0 = {aux_strength_i, main_strength_i};
        next_state.main_sync1 = state.main_sync0;
        next_state.ext_sync = {state.ext_sync[2:0], first_receiver_input_level_i};
        next_state.en_sync = {state.en_sync[1:0], secondary_enable_pin_i, enable_pin_i};
        next_state.en_sync[3:2] = state.en_sync[1:0];

        // Register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                rfid_ctrl_pkg::ADDR_CHIP_STATUS: begin
                    next_state.chip_status = reg_wdata_i;
                end
                rfid_ctrl_pkg::ADDR_PROTOCOL: begin
                    next_state.protocol = reg_wdata_i;
                    // reserved bit held at reader mode
                    next_state.protocol[rfid_ctrl_pkg::PS_READER_BIT] = 1'b0;
                    next_state.hbr_options = rfid_ctrl_pkg::HBR_OPTIONS_RST;
                    next_state.preset = 1'b1;
                end
                rfid_ctrl_pkg::ADDR_HBR_OPTIONS: begin
                    next_state.hbr_options = reg_wdata_i;
                end
                rfid_ctrl_pkg::ADDR_MOD_SYSCLK: begin
                    next_state.mod_sysclk = reg_wdata_i;
                end
                // Status and unmapped writes are dropped
                default: begin
                end
            endcase
        end

        // Register reads, data one cycle after the strobe
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                rfid_ctrl_pkg::ADDR_CHIP_STATUS: next_state.rdata = state.chip_status;
                rfid_ctrl_pkg::ADDR_PROTOCOL: next_state.rdata = state.protocol;
                rfid_ctrl_pkg::ADDR_HBR_OPTIONS: next_state.rdata = state.hbr_options;
                rfid_ctrl_pkg::ADDR_MOD_SYSCLK: next_state.rdata = state.mod_sysclk;
                rfid_ctrl_pkg::ADDR_SIG_STATUS: next_state.rdata = sig_value;
                default: next_state.rdata = rfid_ctrl_pkg::READ_UNMAPPED;
            endcase
        end

        if (reg_rd_i && reg_addr_i == rfid_ctrl_pkg::ADDR_SIG_STATUS) begin
            next_state.main_peak = '0;
            next_state.aux_peak = '0;
            next_state.ext_peak = '0;
        end

        if (tx_start_i) begin
            next_state.main_peak = '0;
            next_state.aux_peak = '0;
            next_state.ext_peak = '0;
        end

        // Measurement sequencer
        unique case (state.meas)
            rfid_ctrl_pkg::MEAS_IDLE: begin
                next_state.meas_count = '0;
            end
            rfid_ctrl_pkg::MEAS_INT, rfid_ctrl_pkg::MEAS_EXT: begin
                if (state.meas_count >= 16'(MEAS_CYCLES - 1)) begin
                    next_state.meas = rfid_ctrl_pkg::MEAS_IDLE;
                    next_state.meas_count = '0;
                end else begin
                    next_state.meas_count = state.meas_count + 16'h0001;
                end
            end
            default: begin
                next_state.meas = rfid_ctrl_pkg::MEAS_IDLE;
            end
        endcase

        // A new 0x18 or 0x19 command restarts a running window
        if (cmd_valid_i) begin
            if (cmd_code_i == rfid_ctrl_pkg::CMD_SIGNAL_STRENGTH_CODE_INT) begin
                next_state.meas = rfid_ctrl_pkg::MEAS_INT;
                next_state.meas_count = '0;
            end
            if (cmd_code_i == rfid_ctrl_pkg::CMD_SIGNAL_STRENGTH_CODE_EXT) begin
                next_state.meas = rfid_ctrl_pkg::MEAS_EXT;
                next_state.meas_count = '0;
            end
        end

        // Window flag registered, not decoded at the pin
        next_state.measuring = next_state.meas != rfid_ctrl_pkg::MEAS_IDLE;

        // peak hold over packet or window; capture beats clear
        capture_int = rx_now || state.meas == rfid_ctrl_pkg::MEAS_INT;
        capture_ext = state.meas == rfid_ctrl_pkg::MEAS_EXT
            || (rx_now && state.chip_status[rfid_ctrl_pkg::CS_EXT_SEL_BIT]);

        if (capture_int) begin
            if (main_now > next_state.main_peak) begin
                next_state.main_peak = main_now;
            end
            if (aux_now > next_state.aux_peak) begin
                next_state.aux_peak = aux_now;
            end
        end
        if (capture_ext && ext_now > next_state.ext_peak) begin
            next_state.ext_peak = ext_now;
        end

        code = next_state.protocol[rfid_ctrl_pkg::PS_CODE_MSB:0];
        next_state.coding_256 = code[0];
        next_state.high_rate = code[1];
        next_state.dual_sub = code[2];
        next_state.rx_rate = rfid_ctrl_pkg::rate_type'(code[1:0]);
        if (code < rfid_ctrl_pkg::CODE_TYPE_A_FIRST) begin
            next_state.family = rfid_ctrl_pkg::FAMILY_VICINITY;
            next_state.rx_rate = rfid_ctrl_pkg::RATE_106;
        end else if (code < rfid_ctrl_pkg::CODE_TYPE_B_FIRST) begin
            next_state.family = rfid_ctrl_pkg::FAMILY_TYPE_A;
        end else if (code <= (rfid_ctrl_pkg::CODE_TYPE_B_FIRST | 5'h03)) begin
            next_state.family = rfid_ctrl_pkg::FAMILY_TYPE_B;
        end else if (code == rfid_ctrl_pkg::CODE_PROP_212) begin
            next_state.family = rfid_ctrl_pkg::FAMILY_PROP;
            next_state.rx_rate = rfid_ctrl_pkg::RATE_212;
        end else if (code == rfid_ctrl_pkg::CODE_PROP_424) begin
            next_state.family = rfid_ctrl_pkg::FAMILY_PROP;
            next_state.rx_rate = rfid_ctrl_pkg::RATE_424;
        end else begin
            next_state.family = rfid_ctrl_pkg::FAMILY_RESERVED;
            next_state.rx_rate = rfid_ctrl_pkg::RATE_106;
        end

        // Vicinity fields read zero elsewhere
        if (code >= rfid_ctrl_pkg::CODE_TYPE_A_FIRST) begin
            next_state.coding_256 = 1'b0;
            next_state.high_rate = 1'b0;
            next_state.dual_sub = 1'b0;
        end

        next_state.tx_rate = next_state.rx_rate;
        if ((next_state.family == rfid_ctrl_pkg::FAMILY_TYPE_A
                || next_state.family == rfid_ctrl_pkg::FAMILY_TYPE_B)
                && next_state.rx_rate == rfid_ctrl_pkg::RATE_212
                && next_state.hbr_options[rfid_ctrl_pkg::HBR_SPLIT_BIT]) begin
            next_state.tx_rate = rfid_ctrl_pkg::rate_type'(
                next_state.hbr_options[rfid_ctrl_pkg::HBR_TX_LSB +: 2]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= '0;
            state.chip_status <= rfid_ctrl_pkg::CHIP_STATUS_RST;
            state.protocol <= rfid_ctrl_pkg::PROTOCOL_RST;
            state.hbr_options <= rfid_ctrl_pkg::HBR_OPTIONS_RST;
            state.mod_sysclk <= rfid_ctrl_pkg::MOD_SYSCLK_RST;
            state.meas <= rfid_ctrl_pkg::MEAS_IDLE;
            state.family <= rfid_ctrl_pkg::FAMILY_VICINITY;
            state.high_rate <= 1'b1;
            state.rx_rate <= rfid_ctrl_pkg::RATE_106;
            state.tx_rate <= rfid_ctrl_pkg::RATE_106;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System clock output
    // Divider runs on the logic clock, which stands for the crystal

    // one clock for carrier and logic
    sysclk_divider u_sysclk_divider (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ratio_i(state.mod_sysclk[rfid_ctrl_pkg::MOD_DIV_LSB +: 2]),
        .low_rate_i(low_rate),
        .clk_out_o(system_clock_out_o)
    );

    // Outputs come straight from state flops
    assign reg_rdata_o = state.rdata;
    assign preset_o = state.preset;
    assign family_o = state.family;
    assign coding_256_o = state.coding_256;
    assign high_rate_o = state.high_rate;
    assign dual_subcarrier_o = state.dual_sub;
    assign rx_rate_o = state.rx_rate;
    assign tx_rate_o = state.tx_rate;
    assign measuring_o = state.measuring;

endmodule

`default_nettype wire

// *** dv/psr_checker_assertions.sv ***
// Port checker for the protocol select and signal strength block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module psr_checker #(
    parameter int MEAS_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic preset_o,
    input wire logic [2:0] family_o,
    input wire logic coding_256_o,
    input wire logic high_rate_o,
    input wire logic dual_subcarrier_o,
    input wire logic [1:0] rx_rate_o,
    input wire logic [1:0] tx_rate_o,
    input wire logic measuring_o,
    input wire logic system_clock_out_o
);
    logic ext_sel;
    logic seen;
    logic [15:0] meas_cnt;
    logic [10:0] run;
    wire logic cmd_ok = cmd_valid_i && (cmd_code_i == 8'h18 || cmd_code_i == 8'h19);
    wire logic wr_ps = reg_wr_i && reg_addr_i == 5'h01;
    wire logic rd_st = reg_rd_i && reg_addr_i == 5'h0F;

    function automatic logic [2:0] fam(input logic [4:0] c);
        if (c < 5'h08) return 3'h0;
        if (c < 5'h0C) return 3'h1;
        if (c < 5'h10) return 3'h2;
        return (c == 5'h1A || c == 5'h1B) ? 3'h3 : 3'h4;
    endfunction

    ////////////////////////////////////////////////////////////
    // Run length of each clock level, counted so ratio hops show
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ext_sel <= 1'b0;
            seen <= 1'b0;
            meas_cnt <= 16'h0000;
            run <= 11'h000;
        end else begin
            if (reg_wr_i && reg_addr_i == 5'h00) ext_sel <= reg_wdata_i[1];
            if ($changed(system_clock_out_o)) seen <= 1'b1;
            meas_cnt <= cmd_ok ? 16'h0000 : meas_cnt + 16'(measuring_o);
            run <= $changed(system_clock_out_o) ? 11'h001 : run + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_preset; wr_ps |=> preset_o; endproperty
    a_preset: assert property (p_preset) else $error("no preset pulse after protocol write");
    property p_preset_cause; preset_o |-> $past(wr_ps); endproperty
    a_preset_cause: assert property (p_preset_cause) else $error("preset pulse without protocol write");
    property p_family; wr_ps |=> family_o == fam($past(reg_wdata_i[4:0])); endproperty
    a_family: assert property (p_family) else $error("protocol family decode wrong");
    property p_vic;
        wr_ps && reg_wdata_i[4:3] == 2'b00 |=> {dual_subcarrier_o, high_rate_o, coding_256_o} == $past(reg_wdata_i[2:0]);
    endproperty
    a_vic: assert property (p_vic) else $error("vicinity fields wrong");
    property p_ab_rate;
        wr_ps && reg_wdata_i[4:3] == 2'b01 |=> rx_rate_o == $past(reg_wdata_i[1:0]) && tx_rate_o == rx_rate_o;
    endproperty
    a_ab_rate: assert property (p_ab_rate) else $error("bit rate decode wrong");
    property p_meas; cmd_ok |=> measuring_o; endproperty
    a_meas: assert property (p_meas) else $error("measurement not started");
    property p_meas_len; $fell(measuring_o) |-> meas_cnt == MEAS_CYCLES; endproperty
    a_meas_len: assert property (p_meas_len) else $error("measurement window length wrong");
    property p_status; rd_st |=> reg_rdata_o[7:6] == 2'b01; endproperty
    a_status: assert property (p_status) else $error("status read out of range");
    property p_ext_src; rd_st && ext_sel |=> reg_rdata_o[5:3] == 3'h0; endproperty
    a_ext_src: assert property (p_ext_src) else $error("aux field set with external source");
    property p_clk_half;
        seen && $changed(system_clock_out_o) |-> run == 1 || run == 2 || run == 4 || run == rfid_ctrl_pkg::LOW_RATE_HALF;
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock output half period wrong");
    property p_clk_live; run <= rfid_ctrl_pkg::LOW_RATE_HALF; endproperty
    a_clk_live: assert property (p_clk_live) else $error("clock output stalled");

    c_meas_end: cover property ($fell(measuring_o));
    c_low_rate: cover property (seen && $changed(system_clock_out_o) && run == rfid_ctrl_pkg::LOW_RATE_HALF);
    c_ext_read: cover property (rd_st && ext_sel);
endmodule

bind protocol_select_signal_strength_code_capture psr_checker #(.MEAS_CYCLES(MEAS_CYCLES)) chk (.clk_sys_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .cmd_valid_i, .cmd_code_i, .reg_rdata_o, .preset_o,
    .family_o, .coding_256_o, .high_rate_o, .dual_subcarrier_o, .rx_rate_o, .tx_rate_o, .measuring_o,
    .system_clock_out_o);
`default_nettype wire

// *** dv/host_model.sv ***
// Host controller model on the byte register and command port.
// Assumes strobes sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int MEAS_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic [4:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o
);
    int since_cmd = 0;
    initial {addr_o, wdata_o, wr_o, rd_o, cmd_valid_o, cmd_code_o} = '0;
    always @(posedge clk_sys_i) since_cmd <= since_cmd + 1;

    // Idle bus shows inverted data, never a stale copy
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) #1;
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(posedge clk_sys_i) #1;
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        while (a == 5'h0F && since_cmd < MEAS_CYCLES) @(posedge clk_sys_i);
        @(posedge clk_sys_i) #1;
        {addr_o, rd_o} = {a, 1'b1};
        @(posedge clk_sys_i) #1;
        d = rdata_i;
        {addr_o, rd_o} = {~a, 1'b0};
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge clk_sys_i) #1;
        {cmd_code_o, cmd_valid_o} = {c, 1'b1};
        @(posedge clk_sys_i) #1;
        {cmd_code_o, cmd_valid_o} = {~c, 1'b0};
        since_cmd = 0;
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Testbench for the protocol select and signal strength block.
// Assumes host_model drives the register port; analog codes come from here.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, tx_start = 1'b0, rx_pkt = 1'b0, en = 1'b1, en2 = 1'b0;
    logic [2:0] mn = 3'h0, ax = 3'h0, ex = 3'h0, fam;
    logic [4:0] addr;
    logic [7:0] wdata, ccode, rdata, d;
    logic wr, rd, cvalid, preset, c256, hr, dual, meas, sclk;
    logic [1:0] rxr, txr;
    int miscompares = 0;
    int check_count = 0;
    always #5 clk_sys_i = ~clk_sys_i;

    host_model #(.MEAS_CYCLES(20)) host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .cmd_valid_o(cvalid), .cmd_code_o(ccode));
    protocol_select_signal_strength_code_capture #(.MEAS_CYCLES(20)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .cmd_valid_i(cvalid),
        .cmd_code_i(ccode), .tx_start_i(tx_start), .rx_packet_i(rx_pkt), .main_strength_i(mn),
        .aux_strength_i(ax), .first_receiver_input_level_i(ex), .enable_pin_i(en), .secondary_enable_pin_i(en2),
        .reg_rdata_o(rdata), .preset_o(preset), .family_o(fam), .coding_256_o(c256), .high_rate_o(hr),
        .dual_subcarrier_o(dual), .rx_rate_o(rxr), .tx_rate_o(txr), .measuring_o(meas),
        .system_clock_out_o(sclk));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(8'(fam), 8'h00);
        check(8'(hr), 8'h01);
        host.rd(5'h01, d);
        check(d, 8'h02);
        host.rd(5'h1E, d);
        check(d, 8'h00);
    endtask

    task automatic t_codes();
        logic [4:0] c;
        // Reserved codes skipped on purpose
        for (int i = 0; i < 18; i++) begin
            c = 5'(i < 16 ? i : i + 10);
            host.wr(5'h01, {3'b001, c});
            check(8'(preset), 8'h01);
            check(8'(fam), 8'(c < 8 ? 0 : c < 12 ? 1 : c < 16 ? 2 : 3));
            check(8'(rxr), 8'(c < 8 ? 0 : c < 16 ? c[1:0] : c - 25));
            if (c < 8) check(8'({dual, hr, c256}), 8'(c[2:0]));
            host.rd(5'h01, d);
            check(d, 8'(c));
        end
    endtask

    task automatic t_split();
        host.wr(5'h01, 8'h0D);
        host.wr(5'h03, 8'h07);
        check(8'({rxr, txr}), 8'h07);
        host.wr(5'h01, 8'h0D);
        check(8'(txr), 8'h01);
        host.rd(5'h03, d);
        check(d, 8'h00);
    endtask

    task automatic t_ext();
        // Carrier checked with transmitter off
        host.wr(5'h00, 8'h02);
        ex = 3'h5;
        host.cmd(8'h19);
        check(8'(meas), 8'h01);
        host.rd(5'h0F, d);
        check(d, 8'h45);
        host.rd(5'h0F, d);
        check(d, 8'h40);
        host.cmd(8'h17);
        check(8'(meas), 8'h00);
    endtask

    task automatic t_int();
        // Transmitter on before internal capture
        host.wr(5'h00, 8'h20);
        {rx_pkt, mn, ax} = {1'b1, 3'h3, 3'h6};
        cycles(6);
        mn = 3'h2;
        cycles(4);
        rx_pkt = 1'b0;
        cycles(4);
        {mn, ax} = {3'h7, 3'h7};
        cycles(4);
        host.rd(5'h0F, d);
        check(d, 8'h73);
        {rx_pkt, mn, ax} = {1'b1, 3'h4, 3'h1};
        cycles(6);
        {rx_pkt, mn, ax} = {1'b0, 3'h2, 3'h5};
        cycles(4);
        tx_start = 1'b1;
        cycles(1);
        tx_start = 1'b0;
        host.rd(5'h0F, d);
        check(d, 8'h40);
        host.cmd(8'h18);
        host.rd(5'h0F, d);
        check(d, 8'h6A);
    endtask

    task automatic half(output int n);
        logic s;
        cycles(20);
        for (int k = 0; k < 2; k++) begin
            s = sclk;
            n = 0;
            while (sclk === s && n < 2000) begin
                cycles(1);
                n++;
            end
            if (n >= 2000) begin
                miscompares++;
                end_of_test();
            end
        end
    endtask

    task automatic t_clk();
        int n;
        for (int k = 0; k < 3; k++) begin
            host.wr(5'h09, 8'(k << 4));
            half(n);
            check(8'(n), 8'(1 << k));
        end
        {en, en2} = 2'b01;
        half(n);
        check(8'(n == rfid_ctrl_pkg::LOW_RATE_HALF), 8'h01);
        {en, en2} = 2'b10;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        cycles(3);
        rst_n_i = 1'b1;
        t_reset();
        t_codes();
        t_split();
        t_ext();
        t_int();
        t_clk();
        end_of_test();
    end
endmodule
`default_nettype wire
